// [hw/sram_if_pkg.sv]
package sram_if_pkg;

    localparam int WORD_W     = 36;
    localparam int BYTE_W     = 9;
    localparam int LANES      = 4;
    localparam int BURST_LEN  = 4;
    localparam int BEAT_W     = 2;
    localparam int ADDR_W     = 19;

    // Read latency counted in clock half cycles (rising edges of k or k_n)
    localparam int LAT_LOOP_HALF   = 5;
    localparam int LAT_LEGACY_HALF = 2;
    localparam int PIPE_DEPTH      = LAT_LOOP_HALF;

    localparam logic              SLOT_READ   = 1'b0;
    localparam logic              SLOT_WRITE  = 1'b1;
    localparam logic              SLOT_RST    = SLOT_READ;
    localparam logic [BEAT_W-1:0] BEAT_RST    = 2'h0;
    localparam logic [BEAT_W-1:0] BEAT_LAST   = 2'h3;
    localparam logic [WORD_W-1:0] WORD_RST    = 36'h0_0000_0000;

    function automatic logic [WORD_W-1:0] byte_merge(
        input logic [WORD_W-1:0] old_word,
        input logic [WORD_W-1:0] new_word,
        input logic [LANES-1:0]  mask_n
    );
        logic [WORD_W-1:0] res;
        res = old_word;
        for (int i = 0; i < LANES; i++)
        begin
            if (!mask_n[i])
                res[i*BYTE_W +: BYTE_W] = new_word[i*BYTE_W +: BYTE_W];
        end
        return res;
    endfunction : byte_merge

endpackage : sram_if_pkg

// [hw/word_buf2.sv]
`timescale 1ns/1ps
module word_buf2 #(
    parameter int W = 8
) (
    input  wire logic         core_clk,
    input  wire logic         rst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    logic [W-1:0] ent_r [2];
    logic [W-1:0] ent_nxt [2];
    logic         wptr_r;
    logic         wptr_nxt;
    logic         rptr_r;
    logic         rptr_nxt;
    logic [1:0]   cnt_r;
    logic [1:0]   cnt_nxt;
    logic         push;
    logic         pop;

    assign in_ready  = (cnt_r != 2'h2);
    assign out_valid = (cnt_r != 2'h0);
    assign out_data  = ent_r[rptr_r];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb
    begin
        ent_nxt[0] = ent_r[0];
        ent_nxt[1] = ent_r[1];
        wptr_nxt   = wptr_r;
        rptr_nxt   = rptr_r;
        cnt_nxt    = cnt_r;
        if (push)
        begin
            ent_nxt[wptr_r] = in_data;
            wptr_nxt        = !wptr_r;
        end
        if (pop)
            rptr_nxt = !rptr_r;
        if (push && !pop)
            cnt_nxt = cnt_r + 2'h1;
        else if (pop && !push)
            cnt_nxt = cnt_r - 2'h1;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            ent_r[0] <= '0;
            ent_r[1] <= '0;
            wptr_r   <= 1'b0;
            rptr_r   <= 1'b0;
            cnt_r    <= 2'h0;
        end
        else
        begin
            ent_r[0] <= ent_nxt[0];
            ent_r[1] <= ent_nxt[1];
            wptr_r   <= wptr_nxt;
            rptr_r   <= rptr_nxt;
            cnt_r    <= cnt_nxt;
        end
    end

endmodule : word_buf2

// [hw/burst_sram_if.sv]
// Functional notes
// RULE1 - Read and write ports run concurrently and independently.
// RULE2 - Shared address bus; read and write slots alternate on k rises.
// RULE3 - Each address holds four consecutive 36-bit words.
// RULE4 - Words move on every rising edge of k and k_n.
// RULE5 - Loop-disable high: read data after 2.5 cycles.
// RULE6 - Loop-disable low: read data after one cycle.
// RULE7 - Every synchronous input captured in registers on k or k_n rises.
// RULE8 - Every data output driven from registers on k or k_n rises.
// RULE9 - Writes complete internally; no write pulse needed.
// RULE10 - Read-valid flag high while output words are valid.
// RULE11 - Complementary echo strobes accompany read data.
// RULE12 - Independent read and write selects allow depth expansion.
// RULE13 - Only rising edges of k and k_n are used.
// RULE14 - Reads return the newest data, including writes in flight.
// RULE15 - Active-low write select on k rise starts a write.
// RULE16 - Deselected read: finish pending burst, then release outputs.
// RULE17 - Four active-low byte masks per word; masked bytes unchanged.
// RULE18 - Read-valid flag is edge aligned with echo strobes.
// RULE19 - Burst words in fixed ascending order from word zero.
// RULE20 - Controller spaces read requests by at least one burst.
`timescale 1ns/1ps
module burst_sram_if #(
    parameter int ADDR_W = sram_if_pkg::ADDR_W
) (
    input  wire logic                           core_clk,
    input  wire logic                           rst,
    input  wire logic                           k_clk,
    input  wire logic                           k_clk_n,
    input  wire logic [ADDR_W-1:0]              addr,
    input  wire logic                           read_port_select_n,
    input  wire logic                           write_port_select_n,
    input  wire logic [sram_if_pkg::LANES-1:0]  byte_lane_mask_n,
    input  wire logic [sram_if_pkg::WORD_W-1:0] wr_data,
    input  wire logic                           loop_disable_sel,
    output logic [sram_if_pkg::WORD_W-1:0]      rd_data,
    output logic                                rd_data_oe,
    output logic                                read_valid_flag,
    output logic                                echo_strobe,
    output logic                                echo_strobe_n
);
    localparam int WW    = sram_if_pkg::WORD_W;
    localparam int LN    = sram_if_pkg::LANES;
    localparam int BW    = sram_if_pkg::BEAT_W;
    localparam int PD    = sram_if_pkg::PIPE_DEPTH;
    localparam int WA_W  = ADDR_W + BW;
    localparam int PIN_W = 5 + LN + ADDR_W + WW;
    localparam int BUF_W = WA_W + LN + WW;

    // Two-stage synchroniser, unreset so it tracks the pins through reset
    logic [PIN_W-1:0] pin_meta_r;
    logic [PIN_W-1:0] pin_sync_r;
    logic             k_prev_r;
    logic             kn_prev_r;

    always_ff @(posedge core_clk)
    begin
        pin_meta_r <= {k_clk, k_clk_n, read_port_select_n,
                       write_port_select_n, loop_disable_sel,
                       byte_lane_mask_n, addr, wr_data};
        pin_sync_r <= pin_meta_r;
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            k_prev_r  <= 1'b1;
            kn_prev_r <= 1'b1;
        end
        else
        begin
            k_prev_r  <= pin_sync_r[PIN_W-1];
            kn_prev_r <= pin_sync_r[PIN_W-2];
        end
    end

    logic              s_k;
    logic              s_kn;
    logic              s_rps_n;
    logic              s_wps_n;
    logic              s_loop_disable_sel;
    logic [LN-1:0]     s_mask_n;
    logic [ADDR_W-1:0] s_addr;
    logic [WW-1:0]     s_data;
    logic              k_rise;
    logic              kn_rise;
    logic              any_rise;

    assign {s_k, s_kn, s_rps_n, s_wps_n, s_loop_disable_sel, s_mask_n, s_addr, s_data}
        = pin_sync_r;
    assign k_rise   = s_k && !k_prev_r;                               // RULE13
    assign kn_rise  = s_kn && !kn_prev_r;                             // RULE13
    assign any_rise = k_rise || kn_rise;                              // RULE4

    // Address slot and read pipeline
    logic              slot_r;
    logic              slot_nxt;
    logic [PD-1:0]     pipe_vld_r;
    logic [PD-1:0]     pipe_vld_nxt;
    logic [ADDR_W-1:0] pipe_addr_r [PD];
    logic [ADDR_W-1:0] pipe_addr_nxt [PD];
    logic              rd_act_r;
    logic              rd_act_nxt;
    logic [BW-1:0]     rd_beat_r;
    logic [BW-1:0]     rd_beat_nxt;
    logic [ADDR_W-1:0] rd_addr_r;
    logic [ADDR_W-1:0] rd_addr_nxt;
    logic [WW-1:0]     rd_data_nxt;
    logic              rd_oe_nxt;
    logic              rvalid_nxt;
    logic              rd_req;
    logic              rd_start;
    logic              fetch_now;
    logic [WA_W-1:0]   fetch_addr;
    logic [WW-1:0]     fetch_word;
    int                lat_idx;

    assign lat_idx = s_loop_disable_sel ? sram_if_pkg::LAT_LOOP_HALF - 1               // RULE5
                            : sram_if_pkg::LAT_LEGACY_HALF - 1;            // RULE6
    assign rd_req  = k_rise && (slot_r == sram_if_pkg::SLOT_READ)
                     && !s_rps_n;                                     // RULE12
    assign rd_start  = any_rise && pipe_vld_r[lat_idx];
    assign fetch_now = rd_start || (any_rise && rd_act_r
                       && (rd_beat_r != sram_if_pkg::BEAT_LAST));

    always_comb
    begin
        slot_nxt     = k_rise ? !slot_r : slot_r;                     // RULE2
        pipe_vld_nxt = pipe_vld_r;
        for (int i = 0; i < PD; i++)
            pipe_addr_nxt[i] = pipe_addr_r[i];
        rd_act_nxt  = rd_act_r;
        rd_beat_nxt = rd_beat_r;
        rd_addr_nxt = rd_addr_r;
        fetch_addr  = {rd_addr_r, rd_beat_r + 2'h1};                  // RULE19
        rd_data_nxt = rd_data;
        rd_oe_nxt   = rd_data_oe;
        rvalid_nxt  = read_valid_flag;
        if (any_rise)
        begin
            pipe_vld_nxt     = {pipe_vld_r[PD-2:0], rd_req};          // RULE7
            pipe_addr_nxt[0] = s_addr;
            for (int i = 1; i < PD; i++)
                pipe_addr_nxt[i] = pipe_addr_r[i-1];
            if (rd_start)
            begin
                rd_act_nxt  = 1'b1;
                rd_beat_nxt = sram_if_pkg::BEAT_RST;                  // RULE19
                rd_addr_nxt = pipe_addr_r[lat_idx];
                fetch_addr  = {pipe_addr_r[lat_idx], sram_if_pkg::BEAT_RST};
            end
            else if (rd_act_r)
            begin
                if (rd_beat_r == sram_if_pkg::BEAT_LAST)              // RULE3
                    rd_act_nxt = 1'b0;
                else
                    rd_beat_nxt = rd_beat_r + 2'h1;
            end
            rvalid_nxt = fetch_now;                                   // RULE10
            if (fetch_now)
            begin
                rd_data_nxt = fetch_word;                             // RULE8
                rd_oe_nxt   = 1'b1;
            end
            else if (k_rise)
                rd_oe_nxt = 1'b0;                                     // RULE16
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            slot_r          <= sram_if_pkg::SLOT_RST;
            pipe_vld_r      <= '0;
            for (int i = 0; i < PD; i++)
                pipe_addr_r[i] <= '0;
            rd_act_r        <= 1'b0;
            rd_beat_r       <= sram_if_pkg::BEAT_RST;
            rd_addr_r       <= '0;
            rd_data         <= sram_if_pkg::WORD_RST;
            rd_data_oe      <= 1'b0;
            read_valid_flag <= 1'b0;
            echo_strobe     <= 1'b0;
            echo_strobe_n   <= 1'b0;
        end
        else
        begin
            slot_r          <= slot_nxt;
            pipe_vld_r      <= pipe_vld_nxt;
            for (int i = 0; i < PD; i++)
                pipe_addr_r[i] <= pipe_addr_nxt[i];
            rd_act_r        <= rd_act_nxt;
            rd_beat_r       <= rd_beat_nxt;
            rd_addr_r       <= rd_addr_nxt;
            rd_data         <= rd_data_nxt;
            rd_data_oe      <= rd_oe_nxt;
            read_valid_flag <= rvalid_nxt;
            echo_strobe     <= s_k;                                   // RULE11
            echo_strobe_n   <= s_kn;                                  // RULE18
        end
    end

    // Write capture
    logic              wr_act_r;
    logic              wr_act_nxt;
    logic [BW-1:0]     wr_beat_r;
    logic [BW-1:0]     wr_beat_nxt;
    logic [ADDR_W-1:0] wr_addr_r;
    logic [ADDR_W-1:0] wr_addr_nxt;
    logic              wr_req;
    logic              buf_in_valid;
    logic              buf_in_ready;
    logic              buf_out_valid;
    logic              buf_out_ready;
    logic [BUF_W-1:0]  buf_out_data;

    assign wr_req = k_rise && (slot_r == sram_if_pkg::SLOT_WRITE)
                    && !s_wps_n;                                      // RULE15
    assign buf_in_valid = any_rise && wr_act_r;                       // RULE4

    always_comb
    begin
        wr_act_nxt  = wr_act_r;
        wr_beat_nxt = wr_beat_r;
        wr_addr_nxt = wr_addr_r;
        if (buf_in_valid && buf_in_ready)
        begin
            if (wr_beat_r == sram_if_pkg::BEAT_LAST)
                wr_act_nxt = 1'b0;
            wr_beat_nxt = wr_beat_r + 2'h1;                           // RULE19
        end
        if (wr_req)
        begin
            wr_act_nxt  = 1'b1;
            wr_beat_nxt = sram_if_pkg::BEAT_RST;
            wr_addr_nxt = s_addr;                                     // RULE2
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            wr_act_r  <= 1'b0;
            wr_beat_r <= sram_if_pkg::BEAT_RST;
            wr_addr_r <= '0;
        end
        else
        begin
            wr_act_r  <= wr_act_nxt;
            wr_beat_r <= wr_beat_nxt;
            wr_addr_r <= wr_addr_nxt;
        end
    end

    // Array port is shared; a read fetch stalls the write drain
    assign buf_out_ready = !fetch_now;                                // RULE1

    word_buf2 #(
        .W (BUF_W)
    ) u_wr_buf (
        .core_clk  (core_clk),
        .rst       (rst),
        .in_valid  (buf_in_valid),
        .in_ready  (buf_in_ready),
        .in_data   ({wr_addr_r, wr_beat_r, s_mask_n, s_data}),        // RULE17
        .out_valid (buf_out_valid),
        .out_ready (buf_out_ready),
        .out_data  (buf_out_data)
    );

    logic [WW-1:0]   mem [2**WA_W];
    logic [WA_W-1:0] drain_addr;
    logic [LN-1:0]   drain_mask_n;
    logic [WW-1:0]   drain_data;
    logic            drain_fire;

    assign {drain_addr, drain_mask_n, drain_data} = buf_out_data;
    assign drain_fire = buf_out_valid && buf_out_ready;

    // Self-timed array write, masked lanes untouched
    always_ff @(posedge core_clk)
    begin
        if (drain_fire)
            mem[drain_addr] <= sram_if_pkg::byte_merge(
                mem[drain_addr], drain_data, drain_mask_n);           // RULE9
    end

    // Bypass of the word still waiting in the buffer
    always_comb
    begin
        fetch_word = mem[fetch_addr];
        if (buf_out_valid && (drain_addr == fetch_addr))
            fetch_word = sram_if_pkg::byte_merge(
                mem[fetch_addr], drain_data, drain_mask_n);           // RULE14
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence edge_s;
        any_rise;
    endsequence

    sequence burst_start_s;
        edge_s ##0 rd_start;
    endsequence

    AST_START_DRIVES: assert property (burst_start_s |=>                // RULE5
        read_valid_flag && rd_data_oe && rd_beat_r == 2'h0)
        else $error("Burst start did not drive first word");
    AST_LAT_SOURCE: assert property ($rose(rd_act_r) |->              // RULE6
        $past(pipe_vld_r[lat_idx]))
        else $error("Burst began without a request at the latency stage");
    AST_FOUR_BEATS: assert property ($fell(rd_act_r) |->               // RULE3
        $past(rd_beat_r) == 2'h3)
        else $error("Read burst ended before four words");
    AST_BEAT_ORDER: assert property (edge_s ##0 (rd_act_r && !rd_start // RULE19
        && rd_beat_r != 2'h3) |=> rd_beat_r == $past(rd_beat_r) + 2'h1)
        else $error("Read beats out of order");
    AST_VALID_ALIGN: assert property ($changed(read_valid_flag) |->    // RULE18
        $changed(echo_strobe) || $changed(echo_strobe_n))
        else $error("Read-valid moved without an echo strobe edge");
    AST_OE_RELEASE: assert property ($fell(rd_data_oe) |->             // RULE16
        $past(k_rise) && !$past(fetch_now))
        else $error("Outputs released off a k rise or mid burst");
    AST_DATA_ON_EDGE: assert property ($changed(rd_data) |->           // RULE13
        $past(any_rise))
        else $error("Read data changed without a clock rise");
    AST_WRITE_DESELECT: assert property (k_rise && !wr_act_r           // RULE15
        && (slot_r == sram_if_pkg::SLOT_WRITE) && s_wps_n |=> !wr_act_r)
        else $error("Write started while deselected");
    AST_SLOT_ALT: assert property (k_rise |=> slot_r != $past(slot_r)) // RULE2
        else $error("Address slot did not alternate");
    AST_DDR_BEATS: assert property (edge_s ##0 fetch_now |=>           // RULE4
        read_valid_flag)
        else $error("Word missed a clock rise");

endmodule : burst_sram_if

// [sim/burst_ctrl_model.sv]
`timescale 1ns/1ps
module burst_ctrl_model #(
    parameter int ADDR_W = 6
) (
    input  wire logic         core_clk,
    input  wire logic         rst,
    output logic              k_clk,
    output logic              k_clk_n,
    output logic [ADDR_W-1:0] addr,
    output logic              read_port_select_n,
    output logic              write_port_select_n,
    output logic [3:0]        byte_lane_mask_n,
    output logic [35:0]       wr_data
);
    logic [2:0]        ph = 3'h4;
    logic              rd_slot = 1'b1;
    logic              rd_pend = 1'b0;
    logic              wr_pend = 1'b0;
    logic              skip = 1'b0;
    logic [ADDR_W-1:0] rd_a;
    logic [ADDR_W-1:0] wr_a;
    logic [39:0]       wq [$];
    logic [39:0]       dq [$];
    realtime           rd_time = 0.0;

    initial
    begin
        k_clk = 1'b0;
        k_clk_n = 1'b1;
        addr = '0;
        read_port_select_n = 1'b1;
        write_port_select_n = 1'b1;
        byte_lane_mask_n = 4'hF;
        wr_data = 36'h0_0000_0000;
    end

    task automatic req_read(input logic [ADDR_W-1:0] a);
        wait (rd_pend == 1'b0);
        rd_a = a;
        rd_pend = 1'b1;
    endtask : req_read

    task automatic req_write(input logic [ADDR_W-1:0] a,
                             input logic [143:0]      w,
                             input logic [15:0]       m);
        wait (wr_pend == 1'b0);
        wr_a = a;
        for (int i = 0; i < 4; i++)
            wq.push_back({m[i*4 +: 4], w[i*36 +: 36]});
        wr_pend = 1'b1;
    endtask : req_write

    function automatic bit idle();
        return !wr_pend && !rd_pend && dq.size() == 0;
    endfunction : idle

    // Eight core cycles per k period; k rises at phase 0
    always @(negedge core_clk)
    begin
        if (rst)
        begin
            ph = 3'h4;
            rd_slot = 1'b1;
        end
        else
        begin
            ph = ph + 3'h1;
            if (ph == 3'h0)
            begin
                k_clk <= 1'b1;
                k_clk_n <= 1'b0;
                if (rd_slot && !read_port_select_n)
                    rd_time = $realtime;
                rd_slot = !rd_slot;
            end
            else if (ph == 3'h4)
            begin
                k_clk <= 1'b0;
                k_clk_n <= 1'b1;
                read_port_select_n <= !(rd_slot && rd_pend);
                write_port_select_n <= !(!rd_slot && wr_pend);
                if (rd_slot && rd_pend)
                begin
                    addr <= rd_a;
                    rd_pend = 1'b0;
                end
                else if (!rd_slot && wr_pend)
                begin
                    addr <= wr_a;
                    skip = (dq.size() == 0);
                    foreach (wq[i]) dq.push_back(wq[i]);
                    wq.delete();
                    wr_pend = 1'b0;
                end
                else
                    addr <= ~addr;
            end
            else if (ph[0] == 1'b0)
            begin
                if (skip)
                    skip = 1'b0;
                else if (dq.size() > 0)
                    {byte_lane_mask_n, wr_data} <= dq.pop_front();
                else
                begin
                    // Released lines never hold the last value
                    wr_data <= ~wr_data;
                    byte_lane_mask_n <= ~byte_lane_mask_n;
                end
            end
        end
    end
endmodule : burst_ctrl_model

// [sim/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    localparam int AW = 6;
    logic          core_clk = 1'b0;
    logic          rst = 1'b1;
    logic          loop_disable_sel = 1'b1;
    logic          k_clk, k_clk_n, read_port_select_n, write_port_select_n;
    logic          rd_data_oe, read_valid_flag, echo_strobe, echo_strobe_n;
    logic          prev_echo = 1'b0;
    logic [AW-1:0] addr;
    logic [3:0]    byte_lane_mask_n;
    logic [35:0]   wr_data, rd_data;
    logic [35:0]   mem [256];
    logic [35:0]   cap [$];
    realtime       cap_t [$];
    int            fail_count = 0;
    int            n_compared = 0;

    always #2 core_clk = ~core_clk;

    burst_ctrl_model #(.ADDR_W(AW)) u_ctrl (
        .core_clk(core_clk), .rst(rst), .k_clk(k_clk), .k_clk_n(k_clk_n),
        .addr(addr), .read_port_select_n(read_port_select_n),
        .write_port_select_n(write_port_select_n),
        .byte_lane_mask_n(byte_lane_mask_n), .wr_data(wr_data));

    burst_sram_if #(.ADDR_W(AW)) dut (
        .core_clk(core_clk), .rst(rst), .k_clk(k_clk), .k_clk_n(k_clk_n),
        .addr(addr), .read_port_select_n(read_port_select_n),
        .write_port_select_n(write_port_select_n),
        .byte_lane_mask_n(byte_lane_mask_n), .wr_data(wr_data),
        .loop_disable_sel(loop_disable_sel), .rd_data(rd_data),
        .rd_data_oe(rd_data_oe), .read_valid_flag(read_valid_flag),
        .echo_strobe(echo_strobe), .echo_strobe_n(echo_strobe_n));

    task automatic chk(input string what, input logic [35:0] exp, got);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic chk_t(input string what, input realtime exp, got);
        n_compared++;
        if (got != exp)
        begin
            fail_count++;
            $display("[FAIL] %s expected %0.1f seen %0.1f", what, exp, got);
        end
    endtask : chk_t

    // One word per echo edge while the flag is high
    always @(negedge core_clk)
    begin
        if (read_valid_flag === 1'b1 && echo_strobe !== prev_echo)
        begin
            cap.push_back(rd_data);
            cap_t.push_back($realtime);
            chk("output enable", 36'h1, 36'(rd_data_oe));
            chk("echo pair", 36'h1, 36'(echo_strobe ^ echo_strobe_n));
        end
        prev_echo = echo_strobe;
    end

    task automatic do_write(input int a, input int s, input logic [15:0] m);
        logic [143:0] w;
        logic [35:0]  v;
        for (int i = 0; i < 4; i++)
        begin
            v = {4'(i), 8'(a), 24'(s)};
            w[i*36 +: 36] = v;
            for (int b = 0; b < 4; b++)
                if (!m[i*4+b])
                    mem[a*4+i][b*9 +: 9] = v[b*9 +: 9];
        end
        u_ctrl.req_write(AW'(a), w, m);
    endtask : do_write

    task automatic drain();
        for (int n = 0; n < 200 && !u_ctrl.idle(); n++)
            @(negedge core_clk);
        chk("drain idle", 36'h1, 36'(u_ctrl.idle()));
        repeat (8) @(negedge core_clk);
    endtask : drain

    task automatic do_read(input int a, output realtime lat);
        cap.delete();
        cap_t.delete();
        lat = 0.0;
        u_ctrl.req_read(AW'(a));
        for (int n = 0; n < 200 && cap.size() < 4; n++)
            @(negedge core_clk);
        repeat (12) @(negedge core_clk);
        chk("burst length", 36'h4, 36'(cap.size()));
        for (int i = 0; i < cap.size() && i < 4; i++)
        begin
            chk("read word", mem[a*4+i], cap[i]);
            if (i > 0)
                chk_t("beat gap", 16.0, cap_t[i] - cap_t[i-1]);
        end
        chk("released oe", 36'h0, 36'(rd_data_oe));
        chk("idle flag", 36'h0, 36'(read_valid_flag));
        if (cap.size() > 0)
            lat = cap_t[0] - u_ctrl.rd_time;
    endtask : do_read

    task automatic t_latency();
        realtime l_hi;
        realtime l_lo;
        do_write(1, 'h111, 16'h0000);
        drain();
        do_read(1, l_hi);
        loop_disable_sel = 1'b0;
        do_read(1, l_lo);
        chk_t("latency step", 48.0, l_hi - l_lo);
        chk("legacy window", 36'h1, 36'(l_lo >= 36.0 && l_lo <= 52.0));
        $display("test latency done");
    endtask : t_latency

    task automatic t_mask();
        realtime l;
        do_write(2, 'h222, 16'h0000);
        do_write(2, 'h333, 16'h7E81);
        do_write(3, 'h444, 16'h0000);
        drain();
        do_read(2, l);
        do_read(3, l);
        $display("test mask done");
    endtask : t_mask

    task automatic t_coherent();
        realtime l;
        do_write(4, 'h555, 16'h0000);
        drain();
        do_write(4, 'h666, 16'hF00F);
        // Read slot must follow the write address slot
        wait (u_ctrl.wr_pend == 1'b0);
        do_read(4, l);
        $display("test coherent done");
    endtask : t_coherent

    task automatic t_concurrent();
        realtime l;
        loop_disable_sel = 1'b1;
        do_write(5, 'h777, 16'h0000);
        do_read(2, l);
        drain();
        do_read(5, l);
        $display("test concurrent done");
    endtask : t_concurrent

    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_of_test

    initial
    begin
        repeat (3) @(negedge core_clk);
        chk("reset data", 36'h0, rd_data);
        chk("reset flags", 36'h0, 36'({rd_data_oe, read_valid_flag}));
        rst = 1'b0;
        t_latency();
        t_mask();
        t_coherent();
        t_concurrent();
        end_of_test();
    end

    // Scenarios need about 2 us
    initial
    begin
        #50000;
        fail_count++;
        end_of_test();
    end
endmodule : tb_top
